// File: core/cnc_emergency_interlock.sv
// Operation
// - all four emergency signals active low
// - core or plc fault drives emergency output
// - halt request stops feed, spindle, reports
// - alarm mark asserted on alarm or emergency
// - stop input or halt stops and reports
// - internal or external malfunction stops and reports
// - every emergency cause asserts output and alarm; the plc real output alone asserts only the output
// - release output and alarm once cause clears; the output also waits until plcOutEmerg_r clears at a scan end
// - plc inputs are stop image and alarm
// - plc outputs are real output and halt
// - scan start refreshes stop input image
// - alarm mark image updated before scan
// - after scan, output follows real output or alarm
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`include "interlock_map.svh"

module cnc_emergency_interlock
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire interlock_pkg::axi_req_s axiReq,
  output interlock_pkg::axi_rsp_s axiRsp,
  input wire logic extStopN,
  input wire logic plcHaltReqN,
  input wire logic plcEmergRealOutputN,
  input wire logic coreFault,
  input wire logic plcFault,
  input wire logic extDevFault,
  output logic emergOutN,
  output logic alarmN,
  output logic feedStop,
  output logic spindleStop,
  output logic [`CAUSE_W-1:0] errCode,
  output logic plcStopRealInput,
  output logic plcAlarmMarkN,
  output logic scanStart,
  output logic irq
);
  import interlock_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] data,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic isMapped(input logic [31:0] addr);
    return addr[31:8] == 24'h00_0000 && (addr[7:0] == `REG_CTRL || addr[7:0] == `REG_STATUS
      || addr[7:0] == `REG_IRQ_STAT || addr[7:0] == `REG_IRQ_MASK || addr[7:0] == `REG_SCAN_CNT);
  endfunction

  // synchroniser and cause detection
  logic extStopMeta_r;
  logic extStopSync_r;
  logic [31:0] ctrl_r;
  logic [`CAUSE_W-1:0] causes;
  logic anyCause;
  logic emergActive_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      extStopMeta_r <= 1'b1;
      extStopSync_r <= 1'b1;
    end
    else
    begin
      extStopMeta_r <= extStopN;
      extStopSync_r <= extStopMeta_r;
    end
  end

  always_comb
  begin
    causes = '0;
    causes[`CAUSE_EXT_STOP] = !extStopSync_r;
    causes[`CAUSE_HALT] = !plcHaltReqN;
    causes[`CAUSE_CORE] = coreFault | ctrl_r[`CTRL_FORCE_FAULT];
    causes[`CAUSE_PLC] = plcFault;
    causes[`CAUSE_EXT_DEV] = extDevFault;
  end
  assign anyCause = |causes;

  a_stop_sync: assert property ((!extStopN ##1 !extStopN) |=> !extStopSync_r)
    else $error("stop input not synchronised in two stages");

  // scan cycle sequencing
  scan_state_e scanState_r;
  logic [`SCAN_CNT_W-1:0] scanTimer_r;
  logic [31:0] scanCount_r;
  logic plcOutEmerg_r;
  logic scanEnd;

  assign scanEnd = scanState_r == SCAN_OUT;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      scanState_r <= SCAN_IN;
      scanTimer_r <= '0;
      scanStart <= 1'b0;
      scanCount_r <= '0;
    end
    else
    begin
      scanStart <= 1'b0;
      case (scanState_r)
        SCAN_IN:
        begin
          if (ctrl_r[`CTRL_SCAN_EN])
          begin
            scanStart <= 1'b1;
            scanTimer_r <= '0;
            scanState_r <= SCAN_RUN;
          end
        end
        SCAN_RUN:
        begin
          scanTimer_r <= scanTimer_r + 1'b1;
          if (scanTimer_r == `SCAN_CNT_W'(`SCAN_CYCLES - 3))
          begin
            scanState_r <= SCAN_OUT;
          end
        end
        SCAN_OUT:
        begin
          scanCount_r <= scanCount_r + 1'b1;
          scanState_r <= SCAN_IN;
        end
        default:
        begin
          scanState_r <= SCAN_IN;
        end
      endcase
    end
  end

  // plc image refresh at scan start, physical output update at scan end
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      plcStopRealInput <= 1'b1;
      plcAlarmMarkN <= 1'b1;
      plcOutEmerg_r <= 1'b0;
    end
    else
    begin
      if (scanState_r == SCAN_IN && ctrl_r[`CTRL_SCAN_EN])
      begin
        plcStopRealInput <= extStopSync_r;
        plcAlarmMarkN <= alarmN;
      end
      if (scanEnd)
      begin
        plcOutEmerg_r <= !plcEmergRealOutputN || !plcAlarmMarkN;
      end
    end
  end

  a_input_refresh: assert property (scanStart |-> plcStopRealInput == $past(extStopSync_r))
    else $error("stop image not refreshed at scan start");
  a_alarm_image: assert property (scanStart |-> plcAlarmMarkN == $past(alarmN))
    else $error("alarm mark image not updated before scan");
  a_scan_output: assert property ((scanEnd && !plcEmergRealOutputN) |=> ##1 !emergOutN)
    else $error("emergency output missed real output at scan end");

  // controller stop and alarm logic
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      feedStop <= 1'b0;
      spindleStop <= 1'b0;
      errCode <= '0;
      alarmN <= 1'b1;
      emergOutN <= 1'b1;
      emergActive_r <= 1'b0;
    end
    else
    begin
      feedStop <= anyCause;
      spindleStop <= anyCause;
      errCode <= causes;
      alarmN <= !anyCause;
      emergOutN <= !(anyCause || plcOutEmerg_r);
      emergActive_r <= anyCause;
    end
  end

  a_halt_stops: assert property (!plcHaltReqN |=>
      feedStop && spindleStop && errCode[`CAUSE_HALT])
    else $error("halt request did not stop feed and spindle");
  a_alarm_mark: assert property (anyCause |=> !alarmN)
    else $error("alarm mark not asserted on emergency");
  a_stop_halts: assert property (!extStopSync_r |=> feedStop && errCode[`CAUSE_EXT_STOP])
    else $error("stop input did not stop feed");
  a_fault_stops: assert property ((coreFault || extDevFault) |=> spindleStop && feedStop)
    else $error("malfunction did not stop feed and spindle");
  a_emerg_both: assert property (anyCause |=> !emergOutN && !alarmN)
    else $error("emergency did not assert both outputs");
  a_plc_fault: assert property (plcFault |=> !emergOutN && errCode[`CAUSE_PLC])
    else $error("plc fault did not drive emergency output");
  a_cause_clear: assert property ((!anyCause && !plcOutEmerg_r) |=> alarmN && emergOutN)
    else $error("outputs not released after cause cleared");

  c_ext_stop: cover property (!extStopSync_r ##1 !emergOutN ##[1:20] extStopSync_r);
  c_halt: cover property (!plcHaltReqN ##1 feedStop);
  c_scan_out: cover property (scanEnd ##2 !emergOutN);

  // axi4-lite slave
  logic awReady_r;
  logic wReady_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic arReady_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic awHeld_r;
  logic wHeld_r;
  logic [31:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awTake;
  logic wTake;
  logic wrFire;
  logic arTake;
  logic awHeld_nxt;
  logic wHeld_nxt;
  logic bValid_nxt;
  logic rValid_nxt;

  always_comb
  begin
    awTake = awReady_r && axiReq.awvalid;
    wTake = wReady_r && axiReq.wvalid;
    wrFire = awHeld_r && wHeld_r && !bValid_r;
    arTake = arReady_r && axiReq.arvalid;
    awHeld_nxt = (awHeld_r || awTake) && !wrFire;
    wHeld_nxt = (wHeld_r || wTake) && !wrFire;
    bValid_nxt = wrFire || (bValid_r && !axiReq.bready);
    rValid_nxt = arTake || (rValid_r && !axiReq.rready);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      awReady_r <= 1'b0;
      wReady_r <= 1'b0;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= `RESP_OKAY;
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= '0;
    end
    else
    begin
      awHeld_r <= awHeld_nxt;
      wHeld_r <= wHeld_nxt;
      bValid_r <= bValid_nxt;
      awReady_r <= !awHeld_nxt && !bValid_nxt;
      wReady_r <= !wHeld_nxt && !bValid_nxt;
      if (awTake)
      begin
        awAddr_r <= axiReq.awaddr;
      end
      if (wTake)
      begin
        wData_r <= axiReq.wdata;
        wStrb_r <= axiReq.wstrb;
      end
      if (wrFire)
      begin
        bResp_r <= isMapped(awAddr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // software registers and interrupts
  logic [`IRQ_W-1:0] irqStat_r;
  logic [`IRQ_W-1:0] irqMask_r;
  logic [`IRQ_W-1:0] irqEvents;
  logic [`IRQ_W-1:0] irqClear;
  logic [`IRQ_W-1:0] irqStat_nxt;
  logic [31:0] clrWord;
  logic [31:0] maskWord;
  logic haltSeen_r;
  logic wrHit;
  logic [31:0] statusWord;

  assign wrHit = wrFire && awAddr_r[31:8] == 24'h00_0000;

  always_comb
  begin
    irqEvents = '0;
    irqEvents[`IRQ_EMERG_SET] = anyCause && !emergActive_r;
    irqEvents[`IRQ_EMERG_CLR] = !anyCause && emergActive_r;
    irqEvents[`IRQ_HALT] = !plcHaltReqN && !haltSeen_r;
    irqClear = '0;
    clrWord = mergeStrb(32'h0000_0000, wData_r, wStrb_r);
    maskWord = mergeStrb({29'h0, irqMask_r}, wData_r, wStrb_r);
    if (wrHit && awAddr_r[7:0] == `REG_IRQ_STAT)
    begin
      irqClear = clrWord[`IRQ_W-1:0];
    end
    irqStat_nxt = (irqStat_r & ~irqClear) | irqEvents;
    statusWord = '0;
    statusWord[`CAUSE_W-1:0] = errCode;
    statusWord[`STAT_EMERG_OUT] = !emergOutN;
    statusWord[`STAT_ALARM] = !alarmN;
    statusWord[`STAT_FEED_STOP] = feedStop;
    statusWord[`STAT_STOP_IMAGE] = !plcStopRealInput;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r <= `CTRL_RESET;
      irqMask_r <= `IRQ_MASK_RESET;
      irqStat_r <= '0;
      haltSeen_r <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      haltSeen_r <= !plcHaltReqN;
      irqStat_r <= irqStat_nxt;
      irq <= |(irqStat_nxt & irqMask_r);
      if (wrHit && awAddr_r[7:0] == `REG_CTRL)
      begin
        ctrl_r <= mergeStrb(ctrl_r, wData_r, wStrb_r) & 32'h0000_0003;
      end
      if (wrHit && awAddr_r[7:0] == `REG_IRQ_MASK)
      begin
        irqMask_r <= maskWord[`IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= `RESP_OKAY;
    end
    else
    begin
      rValid_r <= rValid_nxt;
      arReady_r <= !rValid_nxt;
      if (arTake)
      begin
        rResp_r <= isMapped(axiReq.araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (axiReq.araddr[7:0])
          `REG_CTRL: rData_r <= ctrl_r;
          `REG_STATUS: rData_r <= statusWord;
          `REG_IRQ_STAT: rData_r <= {29'h0, irqStat_r};
          `REG_IRQ_MASK: rData_r <= {29'h0, irqMask_r};
          `REG_SCAN_CNT: rData_r <= scanCount_r;
          default: rData_r <= '0;
        endcase
        if (!isMapped(axiReq.araddr))
        begin
          rData_r <= '0;
        end
      end
    end
  end

  c_irq: cover property (irq ##[1:10] !irq);

  assign axiRsp = {awReady_r, wReady_r, bValid_r, bResp_r, arReady_r, rValid_r, rData_r,
    rResp_r};

endmodule

// File: core/interlock_map.svh
`ifndef INTERLOCK_MAP_SVH
`define INTERLOCK_MAP_SVH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_SCAN_CNT 8'h10

// control register fields and reset value
`define CTRL_SCAN_EN 0
`define CTRL_FORCE_FAULT 1
`define CTRL_RESET 32'h0000_0001

// cause vector positions (status bits 4:0)
`define CAUSE_EXT_STOP 0
`define CAUSE_HALT 1
`define CAUSE_CORE 2
`define CAUSE_PLC 3
`define CAUSE_EXT_DEV 4
`define CAUSE_W 5
`define STAT_EMERG_OUT 5
`define STAT_ALARM 6
`define STAT_FEED_STOP 7
`define STAT_STOP_IMAGE 8

// interrupt status fields
`define IRQ_EMERG_SET 0
`define IRQ_EMERG_CLR 1
`define IRQ_HALT 2
`define IRQ_W 3
`define IRQ_MASK_RESET 3'h0

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// scan timing
`define CLK_PERIOD_NS 10
`define SCAN_PERIOD_NS 10000
`define SCAN_CYCLES (`SCAN_PERIOD_NS / `CLK_PERIOD_NS)
`define SCAN_CNT_W 16

`endif

// File: core/interlock_pkg.sv
package interlock_pkg;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_s;

  typedef enum logic [2:0] {
    SCAN_IN = 3'b001,
    SCAN_RUN = 3'b010,
    SCAN_OUT = 3'b100
  } scan_state_e;

endpackage

// File: dv/cnc_emergency_interlock_tb.sv
`include "interlock_map.svh"
module cnc_emergency_interlock_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import interlock_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  axi_req_s axiReq = '0;
  axi_rsp_s axiRsp;
  logic extStopN = 1'b1;
  logic coreFault = 1'b0;
  logic plcFault = 1'b0;
  logic extDevFault = 1'b0;
  logic haltCmd = 1'b0;
  logic o1Cmd = 1'b0;
  logic plcHaltReqN, plcEmergRealOutputN, emergOutN, alarmN, feedStop, spindleStop;
  logic plcStopRealInput, plcAlarmMarkN, scanStart, irq;
  logic [4:0] errCode;
  logic [31:0] rd;
  logic [31:0] cnt0;
  logic [1:0] rsp;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;

  cnc_emergency_interlock cnc_emergency_interlock_inst (.clk_sys(clk_sys), .rst(rst),
    .axiReq(axiReq), .axiRsp(axiRsp), .extStopN(extStopN), .plcHaltReqN(plcHaltReqN),
    .plcEmergRealOutputN(plcEmergRealOutputN), .coreFault(coreFault), .plcFault(plcFault),
    .extDevFault(extDevFault), .emergOutN(emergOutN), .alarmN(alarmN), .feedStop(feedStop),
    .spindleStop(spindleStop), .errCode(errCode), .plcStopRealInput(plcStopRealInput),
    .plcAlarmMarkN(plcAlarmMarkN), .scanStart(scanStart), .irq(irq));

  plc_scan_model plc_scan_model_inst (.clk_sys(clk_sys), .rst(rst), .scanStart(scanStart),
    .haltCmd(haltCmd), .o1Cmd(o1Cmd), .plcHaltReqN(plcHaltReqN),
    .plcEmergRealOutputN(plcEmergRealOutputN));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic axWrite(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    while (1)
    begin
      @(posedge clk_sys);
      if (axiReq.awvalid && axiRsp.awready)
        axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready)
        axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid)
      begin
        rsp = axiRsp.bresp;
        axiReq.bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axRead(input logic [31:0] a);
    @(posedge clk_sys);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    while (1)
    begin
      @(posedge clk_sys);
      if (axiReq.arvalid && axiRsp.arready)
        axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid)
      begin
        rd = axiRsp.rdata;
        rsp = axiRsp.rresp;
        axiReq.rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic waitScan(input int k);
    int n;
    repeat (k)
    begin
      n = 0;
      do @(posedge clk_sys); while (scanStart !== 1'b1 && ++n < 1100);
    end
    #1;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      finish_test;
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    settle(1);
    chk(32'({emergOutN, alarmN, feedStop, spindleStop, irq}), 32'h0000_0018);
    axRead(`REG_CTRL);
    chk(rd, `CTRL_RESET);
    axRead(32'h0000_0014);
    chk(32'({rd, rsp}), 32'(`RESP_SLVERR));
    axWrite(`REG_IRQ_MASK, 32'h0000_0004);
    chk(32'(rsp), 32'(`RESP_OKAY));
    // halt request from the program
    @(posedge clk_sys);
    haltCmd <= 1'b1;
    settle(3);
    chk(32'({feedStop, spindleStop, alarmN, emergOutN}), 32'h0000_000C);
    chk(32'({errCode, irq}), 32'h0000_0005);
    axRead(`REG_STATUS);
    chk(rd, 32'h0000_00E2);
    waitScan(1);
    chk(32'(plcAlarmMarkN), 32'h0000_0000);
    axWrite(`REG_IRQ_STAT, 32'h0000_0007);
    settle(2);
    chk(32'(irq), 32'h0000_0000);
    @(posedge clk_sys);
    haltCmd <= 1'b0;
    settle(3);
    chk(32'({alarmN, feedStop, spindleStop, errCode}), 32'h0000_0080);
    waitScan(3);
    settle(2);
    chk(32'(emergOutN), 32'h0000_0001);
    // external stop through the synchroniser
    @(posedge clk_sys);
    extStopN <= 1'b0;
    settle(4);
    chk(32'({errCode, feedStop, alarmN}), 32'h0000_0006);
    waitScan(1);
    chk(32'(plcStopRealInput), 32'h0000_0000);
    @(posedge clk_sys);
    extStopN <= 1'b1;
    settle(4);
    chk(32'(errCode), 32'h0000_0000);
    // core, plc and external device faults
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_sys);
      {extDevFault, plcFault, coreFault} <= 3'(1 << i);
      settle(3);
      chk(32'({errCode, emergOutN, alarmN}), 32'h0000_0010 << i);
      @(posedge clk_sys);
      {extDevFault, plcFault, coreFault} <= 3'h0;
    end
    axWrite(`REG_CTRL, 32'h0000_0003);
    settle(3);
    chk(32'({errCode, emergOutN}), 32'h0000_0008);
    axWrite(`REG_CTRL, 32'h0000_0001);
    // real output copied to the emergency output at scan end
    @(posedge clk_sys);
    o1Cmd <= 1'b1;
    waitScan(3);
    settle(2);
    chk(32'({emergOutN, alarmN, feedStop}), 32'h0000_0002);
    @(posedge clk_sys);
    o1Cmd <= 1'b0;
    waitScan(3);
    settle(2);
    chk(32'(emergOutN), 32'h0000_0001);
    axRead(`REG_SCAN_CNT);
    cnt0 = rd;
    waitScan(1);
    axRead(`REG_SCAN_CNT);
    chk(rd - cnt0, 32'h0000_0001);
    finish_test;
  end
endmodule

// File: dv/plc_scan_model.sv
module plc_scan_model
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scanStart,
  input wire logic haltCmd,
  input wire logic o1Cmd,
  output logic plcHaltReqN,
  output logic plcEmergRealOutputN
);
  timeunit 1ns;
  timeprecision 1ps;

  // user program drives the halt mark, active low
  assign plcHaltReqN = ~haltCmd;

  // real output written once per scan by the user program
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      plcEmergRealOutputN <= 1'b1;
    else if (scanStart)
      plcEmergRealOutputN <= ~o1Cmd;
  end
endmodule
